/* File: design/display_rail_pulse_control.sv */
`timescale 1ns/100ps
`include "rail_defs.svh"
module display_rail_pulse_control
   import rail_pkg::*;
#(
   parameter logic [17:0] NEG_DELAY_CYC = 18'(`NEG_DELAY_CYC),
   parameter logic [17:0] NEG_REG_CYC   = 18'(`NEG_REG_CYC),
   parameter logic [17:0] SCP_CYC       = 18'(`SCP_CYC)
)(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   // pins
   input  wire logic        edge_line_in,
   input  wire logic        aux_enable_in,
   input  wire logic        supply_lockout_in,
   // analog comparators
   input  wire logic        pos_in_regulation_in,
   input  wire logic        pos_below_limit_in,
   input  wire logic        neg_in_regulation_in,
   input  wire logic        neg_above_startup_limit_in,
   input  wire logic        neg_above_nominal_in,
   // rail controls
   output logic             pos_rail_en_out,
   output logic             pos_reduced_limit_out,
   output logic             neg_rail_en_out,
   output logic             switching_en_out,
   output logic             discharge_en_out,
   output logic             aux_rail_en_out,
   output logic             fault_latched_out,
   output level_code_t      neg_level_code_out,
   // axi4-lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [6:0] pin_meta;
   logic [6:0] pin_sync;

   always_ff @(posedge clk_in) begin
      pin_meta <= {aux_enable_in, supply_lockout_in, pos_in_regulation_in,
                   pos_below_limit_in, neg_in_regulation_in,
                   neg_above_startup_limit_in, neg_above_nominal_in};
      pin_sync <= pin_meta;
   end

   wire aux_s       = pin_sync[6];
   wire lockout_s   = pin_sync[5];
   wire pos_ok_s    = pin_sync[4];
   wire pos_low_s   = pin_sync[3];
   wire neg_ok_s    = pin_sync[2];
   wire neg_short_s = pin_sync[1];
   wire neg_high_s  = pin_sync[0];

   // ----------------------------------------
   // edge counting and ramp
   // ----------------------------------------
   pulse_if pulses ();

   rail_state_e state;
   rail_state_e next_state;
   level_code_t target_code;
   level_code_t ramp_level;
   logic        hiz_mode;
   logic        sw_disable;
   logic [17:0] t_cnt;
   logic [17:0] pos_low_cnt;
   logic [17:0] neg_high_cnt;

   wire counting   = (state != ST_OFF);
   wire pos_on     = (state == ST_POS_START) || (state == ST_NEG_START) || (state == ST_RUN);
   wire neg_on     = (state == ST_NEG_START) || (state == ST_RUN);
   wire in_start   = (state == ST_POS_START) || (state == ST_NEG_START);
   wire enable_ok  = pulses.line_high && !lockout_s && !sw_disable;
   wire rails_kill = lockout_s || pulses.long_low || sw_disable;
   wire pos_check  = (state == ST_POS_START) && (t_cnt == NEG_DELAY_CYC - 18'h00001);
   wire neg_check  = (state == ST_NEG_START) && (t_cnt == NEG_REG_CYC - 18'h00001);
   wire pos_scp    = pos_low_s && (pos_low_cnt == SCP_CYC - 18'h00001);
   wire neg_scp    = neg_high_s && (neg_high_cnt == SCP_CYC - 18'h00001);
   wire code_in    = pulses.count <= `CODE_MAX;

   assign pulses.count_en = counting;

   edge_count_rx u_rx (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .line_raw_in(edge_line_in),
      .pulses     (pulses.rx)
   );

   // rail held at its level while off, so it starts at the programmed code
   dac_ramp u_ramp (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (!neg_on),
      .target_in  (level_index(target_code)),
      .level_out  (ramp_level)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (enable_ok)
               next_state = ST_POS_START;
         end
         ST_POS_START: begin
            if (pos_check)
               next_state = (!pos_ok_s || neg_short_s) ? ST_FAULT : ST_NEG_START;
         end
         ST_NEG_START: begin
            if (neg_check)
               next_state = neg_ok_s ? ST_RUN : ST_FAULT;
         end
         ST_RUN: begin
            if (pos_scp || neg_scp)
               next_state = ST_FAULT;
         end
         ST_FAULT: next_state = ST_FAULT;
         default:  next_state = ST_OFF;
      endcase
      if (rails_kill)
         next_state = ST_OFF;
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // elapsed time since enable; runs through both start phases
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !in_start)
         t_cnt <= 18'h00000;
      else
         t_cnt <= t_cnt + 18'h00001;
   end

   // ----------------------------------------
   // short-circuit timers in operation
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || state != ST_RUN) begin
         pos_low_cnt  <= 18'h00000;
         neg_high_cnt <= 18'h00000;
      end else begin
         pos_low_cnt  <= pos_low_s ? pos_low_cnt + 18'h00001 : 18'h00000;
         neg_high_cnt <= neg_high_s ? neg_high_cnt + 18'h00001 : 18'h00000;
      end
   end

   // ----------------------------------------
   // programmed code and shutdown mode
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         target_code <= 6'h00;
         hiz_mode    <= 1'b0;
      end else if (state == ST_OFF) begin
         target_code <= 6'h00;
      end else if (pulses.accept) begin
         if (code_in)
            target_code <= pulses.count;
         else if (pulses.count == `CODE_HIZ)
            hiz_mode <= 1'b1;
         else if (pulses.count == `CODE_DISCHARGE)
            hiz_mode <= 1'b0;
      end
   end

   // ----------------------------------------
   // registered rail outputs
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pos_rail_en_out       <= 1'b0;
         pos_reduced_limit_out <= 1'b0;
         neg_rail_en_out       <= 1'b0;
         switching_en_out      <= 1'b0;
         discharge_en_out      <= 1'b0;
         aux_rail_en_out       <= 1'b0;
         fault_latched_out     <= 1'b0;
      end else begin
         pos_rail_en_out       <= pos_on;
         pos_reduced_limit_out <= (state == ST_POS_START);
         neg_rail_en_out       <= neg_on;
         switching_en_out      <= pos_on;
         discharge_en_out      <= !pos_on && !hiz_mode;
         aux_rail_en_out       <= aux_s;
         fault_latched_out     <= (state == ST_FAULT);
      end
   end

   assign neg_level_code_out = ramp_level;

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   function automatic logic addr_hit(input logic [3:0] addr);
      addr_hit = (addr == `REG_STATUS) || (addr == `REG_LEVEL) || (addr == `REG_CONTROL);
   endfunction : addr_hit

   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic        w_lane0;

   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire ar_take  = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire [31:0] status_word = {25'h0000000, lockout_s, hiz_mode, 1'b0,
                              (state == ST_FAULT), 3'(state)};
   wire [31:0] level_word  = {18'h00000, level_index(target_code), 2'h0, ramp_level};
   wire [31:0] read_word   = (s_axi_araddr == `REG_STATUS)  ? status_word :
                             (s_axi_araddr == `REG_LEVEL)   ? level_word  :
                             (s_axi_araddr == `REG_CONTROL) ? {31'h00000000, sw_disable} :
                                                              32'h00000000;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h00000000;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // only the control word is writable; status words ignore writes
   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         sw_disable <= `CONTROL_RESET;
      else if (do_write && aw_addr == `REG_CONTROL && w_lane0)
         sw_disable <= w_data[0];
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= read_word;
         s_axi_rresp  <= addr_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_enable;
      state == ST_OFF ##1 state == ST_POS_START;
   endsequence

   property p_default_on_enable;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_enable |-> target_code == 6'h00 ##1 pos_reduced_limit_out && !neg_rail_en_out;
   endproperty
   a_default_on_enable: assert property (p_default_on_enable) else $error("bad start");

   property p_code_apply;
      @(posedge clk_in) disable iff (!reset_n_in)
      counting && pulses.accept && code_in && !rails_kill |=> target_code == $past(pulses.count);
   endproperty
   a_code_apply: assert property (p_code_apply) else $error("code not applied");

   property p_aux_follow;
      @(posedge clk_in) disable iff (!reset_n_in)
      aux_s |=> aux_rail_en_out;
   endproperty
   a_aux_follow: assert property (p_aux_follow) else $error("aux not enabled");

   property p_neg_waits;
      @(posedge clk_in) disable iff (!reset_n_in)
      $rose(neg_rail_en_out) |-> $past(state) == ST_NEG_START && $past(t_cnt) == NEG_DELAY_CYC;
   endproperty
   a_neg_waits: assert property (p_neg_waits) else $error("negative rail early");

   property p_off_quiet;
      @(posedge clk_in) disable iff (!reset_n_in)
      state == ST_OFF |=> !pos_rail_en_out && !switching_en_out;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("rails on while off");

   property p_lockout_off;
      @(posedge clk_in) disable iff (!reset_n_in)
      lockout_s |=> state == ST_OFF ##1 !pos_rail_en_out;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("runs in lockout");

   property p_run_scp;
      @(posedge clk_in) disable iff (!reset_n_in)
      state == ST_RUN && pos_scp && !rails_kill |=> state == ST_FAULT ##1 !pos_rail_en_out;
   endproperty
   a_run_scp: assert property (p_run_scp) else $error("short not latched");

   property p_fault_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      state == ST_FAULT && !rails_kill |=> state == ST_FAULT;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault released");

   property p_start_fault;
      @(posedge clk_in) disable iff (!reset_n_in)
      pos_check && !pos_ok_s && !rails_kill |=> state == ST_FAULT;
   endproperty
   a_start_fault: assert property (p_start_fault) else $error("start fault missed");

   property p_hiz_mode;
      @(posedge clk_in) disable iff (!reset_n_in)
      counting && pulses.accept && pulses.count == `CODE_HIZ |=> hiz_mode ##1 !discharge_en_out;
   endproperty
   a_hiz_mode: assert property (p_hiz_mode) else $error("hiz not set");
endmodule : display_rail_pulse_control

/* File: pkg/rail_defs.svh */
`ifndef RAIL_DEFS_SVH
`define RAIL_DEFS_SVH
// Notes on behaviour
// - rising enable loads default negative code (-2.2 V) before any edge counting
// - once enabled, every rising edge on the line is counted, saturating at 63, as the program value
// - 6-bit code: 0 keeps -2.2 V, 1 is -4.4 V, +0.1 V per edge to 31
// - negative rail ramps one level per 300 us transition interval
// - auxiliary regulator follows its own enable pin, independent of the line
// - line high starts boost with reduced limit; negative rail 10 ms later
// - boost start does not wait for the auxiliary regulator
// - rails enabled while line high, disabled and switching off while low
// - device stays disabled while supply lockout is asserted
// - running: boost low or negative 500 mV high for over 3 ms latches shutdown
// - fault shutdown held until supply lockout or line low then high; the code also releases it when the control register disable bit is set
// - start-up faults checked at 10 ms (boost, negative short) and 20 ms
// - negative start-up short uses the 250 mV threshold comparator
// - count 50 selects high impedance off, count 51 selects discharge
// - after reset the shutdown behaviour is active discharge
// - start-up begins only with supply above lockout and line high

// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_MHZ            10
`define NEG_DELAY_US       10000
`define NEG_DELAY_CYC      (`NEG_DELAY_US * `CLK_MHZ)
`define NEG_REG_US         20000
`define NEG_REG_CYC        (`NEG_REG_US * `CLK_MHZ)
`define SCP_US             3000
`define SCP_CYC            (`SCP_US * `CLK_MHZ)
`define STEP_US            300
`define STEP_CYC           (`STEP_US * `CLK_MHZ)
`define ACCEPT_US          30
`define ACCEPT_CYC         (`ACCEPT_US * `CLK_MHZ)
`define DISABLE_US         30
`define DISABLE_CYC        (`DISABLE_US * `CLK_MHZ)

// ----------------------------------------
// codes
// ----------------------------------------
`define CODE_DEFAULT_LEVEL 6'h17
`define CODE_MAX           6'h1f
`define CODE_HIZ           6'h32
`define CODE_DISCHARGE     6'h33
`define COUNT_SAT          6'h3f

// ----------------------------------------
// register map
// ----------------------------------------
`define REG_STATUS         4'h0
`define REG_LEVEL          4'h4
`define REG_CONTROL        4'h8
`define CONTROL_RESET      1'b0
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

/* File: pkg/rail_pkg.sv */
`include "rail_defs.svh"
package rail_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_POS_START,
      ST_NEG_START,
      ST_RUN,
      ST_FAULT
   } rail_state_e;

   typedef logic [5:0] level_code_t;

   // code 0 means the default level
   function automatic level_code_t level_index(input level_code_t code);
      level_index = (code == 6'h00) ? `CODE_DEFAULT_LEVEL : code;
   endfunction : level_index
endpackage : rail_pkg

/* File: pkg/pulse_if.sv */
`timescale 1ns/100ps
interface pulse_if;
   logic       line_high;
   logic       rise;
   logic       accept;
   logic       long_low;
   logic [5:0] count;
   logic       count_en;

   modport rx  (output line_high, rise, accept, long_low, count, input count_en);
   modport ctl (input line_high, rise, accept, long_low, count, output count_en);
endinterface : pulse_if

/* File: design/edge_count_rx.sv */
`timescale 1ns/100ps
`include "rail_defs.svh"
module edge_count_rx
   import rail_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   // raw line
   input  wire logic line_raw_in,
   // to control
   pulse_if.rx       pulses
);
   logic       line_meta;
   logic       line_sync;
   logic       line_prev;
   logic [8:0] high_cnt;
   logic [8:0] low_cnt;
   logic [5:0] count;

   wire rise_w   = line_sync & ~line_prev;
   wire accept_w = line_sync & (high_cnt == 9'(`ACCEPT_CYC - 1)) & (count != 6'h00);
   wire long_w   = (low_cnt == 9'(`DISABLE_CYC));

   always_ff @(posedge clk_in) begin
      line_meta <= line_raw_in;
      line_sync <= line_meta;
      line_prev <= line_sync;
   end

   // ----------------------------------------
   // phase timers, saturating
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         high_cnt <= 9'h000;
         low_cnt  <= 9'h000;
      end else begin
         high_cnt <= !line_sync ? 9'h000 :
                     (high_cnt == 9'(`ACCEPT_CYC)) ? high_cnt : high_cnt + 9'h001;
         low_cnt  <= line_sync ? 9'h000 : long_w ? low_cnt : low_cnt + 9'h001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         count <= 6'h00;
      else if (accept_w || long_w)
         count <= 6'h00;
      else if (rise_w && pulses.count_en && count != `COUNT_SAT)
         count <= count + 6'h01;
   end

   assign pulses.line_high = line_sync;
   assign pulses.rise      = rise_w;
   assign pulses.accept    = accept_w;
   assign pulses.long_low  = long_w;
   assign pulses.count     = count;

   property p_count_step;
      @(posedge clk_in) disable iff (!reset_n_in)
      rise_w && pulses.count_en && count < 6'h3e |=> count == $past(count) + 6'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("edge not counted");
endmodule : edge_count_rx

/* File: design/dac_ramp.sv */
`timescale 1ns/100ps
`include "rail_defs.svh"
module dac_ramp
   import rail_pkg::*;
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         reset_n_in,
   // control
   input  wire logic         load_in,
   input  wire level_code_t  target_in,
   // level
   output level_code_t       level_out
);
   logic [11:0] div;

   wire step = (div == 12'(`STEP_CYC - 1));

   // load jumps straight to target while the rail is off
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         div       <= 12'h000;
         level_out <= `CODE_DEFAULT_LEVEL;
      end else if (load_in) begin
         div       <= 12'h000;
         level_out <= target_in;
      end else begin
         div <= step ? 12'h000 : div + 12'h001;
         if (step && level_out != target_in)
            level_out <= (level_out < target_in) ? level_out + 6'h01 : level_out - 6'h01;
      end
   end

   property p_ramp_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      !load_in && !step |=> level_out == $past(level_out);
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("level moved between steps");

   property p_ramp_step;
      @(posedge clk_in) disable iff (!reset_n_in)
      !load_in && step && level_out < target_in |=> level_out == $past(level_out) + 6'h01;
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("level did not step");
endmodule : dac_ramp

/* File: dv/edge_line_host.sv */
`timescale 1ns/100ps
module edge_line_host (
   // clock
   input  wire logic clk_in,
   // program line, idles low like the pin pull-down
   output logic      line_out
);
   initial line_out = 1'b0;

   task automatic hold(input logic v, input int n);
      line_out <= v;
      repeat (n) @(posedge clk_in);
   endtask : hold

   // 10 us phases at 10 MHz, then stay high past the accept period
   task automatic pulses(input int k);
      repeat (k) begin
         hold(1'b0, 100);
         hold(1'b1, 100);
      end
      hold(1'b1, 400);
   endtask : pulses

   task automatic low_hold;
      hold(1'b0, 2100);
   endtask : low_hold
endmodule : edge_line_host

/* File: dv/display_rail_pulse_control_tb.sv */
`timescale 1ns/100ps
`include "rail_defs.svh"
module display_rail_pulse_control_tb;
   import rail_pkg::*;
   logic clk_in = 1'b0, reset_n_in, edge_line_in, aux_enable_in, supply_lockout_in;
   logic pos_in_regulation_in, pos_below_limit_in, neg_in_regulation_in;
   logic neg_above_startup_limit_in, neg_above_nominal_in;
   logic pos_rail_en_out, pos_reduced_limit_out, neg_rail_en_out, switching_en_out;
   logic discharge_en_out, aux_rail_en_out, fault_latched_out;
   level_code_t neg_level_code_out;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int error_cnt = 0;
   int n_tests = 0;

   display_rail_pulse_control #(.NEG_DELAY_CYC(18'd40), .NEG_REG_CYC(18'd80),
      .SCP_CYC(18'd20)) dut (.*);
   edge_line_host host (.clk_in(clk_in), .line_out(edge_line_in));

   initial forever #50 clk_in = ~clk_in;

   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask : w

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_in);
   endtask : rd_reg

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic t_reset;
      chk("code", `CODE_DEFAULT_LEVEL, neg_level_code_out);
      w(10);
      chk("discharge", 1, discharge_en_out);
      rd_reg(`REG_CONTROL);
      chk("control", 0, rd);
      rd_reg(4'hc);
      chk("rd_unmapped", 0, rd);
      chk("rresp", `RESP_SLVERR, rs);
      wr_reg(4'hc, 1);
      chk("bresp", `RESP_SLVERR, rs);
      aux_enable_in <= 1'b1;
      w(6);
      chk("aux_on", 1, aux_rail_en_out);
      chk("pos_off", 0, pos_rail_en_out);
      aux_enable_in <= 1'b0;
      w(6);
      chk("aux_off", 0, aux_rail_en_out);
      $display("test reset done");
   endtask : t_reset

   task automatic t_start;
      host.hold(1'b1, 8);
      chk("pos_en", 1, pos_rail_en_out);
      chk("reduced", 1, pos_reduced_limit_out);
      chk("switching", 1, switching_en_out);
      chk("neg_early", 0, neg_rail_en_out);
      w(60);
      chk("neg_en", 1, neg_rail_en_out);
      w(60);
      rd_reg(`REG_STATUS);
      chk("state_run", 3, rd[2:0]);
      host.pulses(20);
      rd_reg(`REG_LEVEL);
      chk("target", 20, rd[13:8]);
      w(3200);
      chk("ramp_one", 22, neg_level_code_out);
      w(6000);
      chk("ramp_end", 20, neg_level_code_out);
      $display("test start done");
   endtask : t_start

   task automatic t_fault;
      host.pulses(50);
      rd_reg(`REG_STATUS);
      chk("hiz", 1, rd[5]);
      pos_below_limit_in <= 1'b1;
      w(40);
      chk("fault_pos", 1, fault_latched_out);
      chk("pos_shut", 0, pos_rail_en_out);
      pos_below_limit_in <= 1'b0;
      w(20);
      chk("held", 1, fault_latched_out);
      host.low_hold();
      chk("cleared", 0, fault_latched_out);
      chk("code_back", `CODE_DEFAULT_LEVEL, neg_level_code_out);
      chk("hiz_off", 0, discharge_en_out);
      host.hold(1'b1, 120);
      chk("restart", 1, pos_rail_en_out);
      host.pulses(51);
      rd_reg(`REG_STATUS);
      chk("dis_mode", 0, rd[5]);
      neg_above_nominal_in <= 1'b1;
      w(40);
      chk("fault_neg", 1, fault_latched_out);
      neg_above_nominal_in <= 1'b0;
      host.low_hold();
      chk("discharge", 1, discharge_en_out);
      $display("test fault done");
   endtask : t_fault

   task automatic t_startup;
      pos_in_regulation_in <= 1'b0;
      host.hold(1'b1, 60);
      chk("fault_boost", 1, fault_latched_out);
      chk("neg_held", 0, neg_rail_en_out);
      supply_lockout_in <= 1'b1;
      w(10);
      chk("lock_clear", 0, fault_latched_out);
      chk("lock_off", 0, pos_rail_en_out);
      pos_in_regulation_in <= 1'b1;
      host.low_hold();
      supply_lockout_in <= 1'b0;
      neg_above_startup_limit_in <= 1'b1;
      host.hold(1'b1, 60);
      chk("fault_short", 1, fault_latched_out);
      neg_above_startup_limit_in <= 1'b0;
      host.low_hold();
      wr_reg(`REG_CONTROL, 1);
      chk("bresp_ok", `RESP_OKAY, rs);
      rd_reg(`REG_CONTROL);
      chk("control", 1, rd);
      s_axi_wstrb <= 4'h0;
      wr_reg(`REG_CONTROL, 0);
      s_axi_wstrb <= 4'hf;
      chk("bresp_lane", `RESP_OKAY, rs);
      rd_reg(`REG_CONTROL);
      chk("lane_off", 1, rd);
      host.hold(1'b1, 20);
      chk("sw_block", 0, pos_rail_en_out);
      wr_reg(`REG_CONTROL, 0);
      host.low_hold();
      neg_in_regulation_in <= 1'b0;
      host.hold(1'b1, 60);
      chk("neg_reg_wait", 0, fault_latched_out);
      w(40);
      chk("fault_neg_reg", 1, fault_latched_out);
      reset_n_in <= 1'b0;
      w(3);
      chk("rst_fault", 0, fault_latched_out);
      reset_n_in <= 1'b1;
      neg_in_regulation_in <= 1'b1;
      w(6);
      chk("rst_restart", 1, pos_rail_en_out);
      host.low_hold();
      $display("test startup done");
   endtask : t_startup

   initial begin
      reset_n_in = 1'b0;
      {aux_enable_in, supply_lockout_in, pos_below_limit_in, neg_above_nominal_in} = '0;
      {pos_in_regulation_in, neg_in_regulation_in, neg_above_startup_limit_in} = 3'b110;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      w(5);
      reset_n_in <= 1'b1;
      w(1);
      t_reset();
      t_start();
      t_fault();
      t_startup();
      report_and_stop();
   end

   // the tests need about 50000 cycles
   initial begin
      w(100000);
      error_cnt++;
      report_and_stop();
   end
endmodule : display_rail_pulse_control_tb
